// ==== cidr_pkg.sv ====
// Purpose: constants and types of the index/data configuration register bank
// Assumes: one 125 MHz clock, host strobes already decoded to one-cycle pulses
// Notes:   registers store fixed bits too; they are forced on write and again on read
package cidr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [7:0] IDX_PIN_FUNC = 8'h00;
  localparam logic [7:0] IDX_PAR_LOCK = 8'h01;
  localparam logic [7:0] IDX_SER_PWR  = 8'h02;
  // last index that the lock covers
  localparam logic [7:0] IDX_LOCK_TOP = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_PIN_FUNC = 8'h28;
  localparam logic [7:0] RST_PAR_LOCK = 8'h9c;
  localparam logic [7:0] RST_SER_PWR  = 8'h88;
  localparam logic [7:0] RST_INDEX    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // writable masks and fixed read values
  localparam logic [7:0] WMASK_PIN_FUNC = 8'h8b;
  localparam logic [7:0] FIXED_PIN_FUNC = 8'h20;
  localparam logic [7:0] WMASK_PAR_LOCK = 8'h8c;
  localparam logic [7:0] FIXED_PAR_LOCK = 8'h10;
  localparam logic [7:0] WMASK_SER_PWR  = 8'h88;
  localparam logic [7:0] FIXED_SER_PWR  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PIN_MODE_LO   = 0;
  localparam int PIN_MODE_HI   = 1;
  localparam int FDC_PWR_BIT   = 3;
  localparam int VALID_BIT     = 7;
  localparam int PP_PWR_BIT    = 2;
  localparam int PP_MODE_BIT   = 3;
  localparam int LOCK_BIT      = 7;
  localparam int PRIMARY_SERIAL_PORT_PWR_BIT = 3;
  localparam int SECONDARY_SERIAL_PORT_PWR_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    PIN_OFF,
    PIN_IDE,
    PIN_ALT_IR
  } cidr_pin_mode_t;

  typedef struct packed {
    logic       idx_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } cidr_host_req_t;

  typedef struct packed {
    logic ide_enable;
    logic alt_ir_enable;
    logic pullup_enable;
    logic fdc_power;
    logic valid_flag;
    logic pp_power;
    logic pp_extended;
    logic write_lock_open;
    logic primary_serial_port_power;
    logic secondary_serial_port_power;
  } cidr_ctrl_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } cidr_sync_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] pin_function_fdc_power;
    logic [7:0] parallel_mode_and_lock;
    logic [7:0] serial_power_control;
    logic [7:0] rd_data;
    logic       rd_valid;
    cidr_ctrl_t ctrl;
  } cidr_state_t;

endpackage : cidr_pkg

// ==== cidr_sync3.sv ====
// Purpose: three-stage synchroniser for a level from a pin
// Assumes: async input, active-high async reset
// Notes:   the level moves only once stages two and three agree
`timescale 1ns/1ps
module cidr_sync3
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // level
  input  wire logic async_i,
  output logic      level_o
);

  cidr_pkg::cidr_sync_t st_q;
  cidr_pkg::cidr_sync_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.level = st_q.s3;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

endmodule : cidr_sync3

// ==== cidr_pin_decode.sv ====
// Purpose: decode of the IDE / alternate IR pin field
// Assumes: purely combinational, registered by the caller
// Notes:   code 01 is reserved and behaves as 00
`timescale 1ns/1ps
module cidr_pin_decode
(
  // field
  input  wire logic [1:0] mode_field_i,
  // decoded enables
  output logic            ide_enable_o,
  output logic            alt_ir_enable_o,
  output logic            pullup_enable_o
);

  cidr_pkg::cidr_pin_mode_t mode;

  always_comb
  begin
    case (mode_field_i)
      2'b10:   mode = cidr_pkg::PIN_IDE;
      2'b11:   mode = cidr_pkg::PIN_ALT_IR;
      default: mode = cidr_pkg::PIN_OFF;
    endcase
  end

  assign ide_enable_o    = (mode == cidr_pkg::PIN_IDE);
  assign alt_ir_enable_o = (mode == cidr_pkg::PIN_ALT_IR);
  // pull-ups only while the pins have no owner, so they never fight a driver
  assign pullup_enable_o = (mode == cidr_pkg::PIN_OFF);

endmodule : cidr_pin_decode

// ==== cidr_config_regs.sv ====
// Purpose: index/data configuration register bank, indices 00h to 02h
// Assumes: host strobes are one-cycle pulses on ref_clk_i; cfg_mode_i comes
//          from the key-sequence logic on the same clock
// Notes:   reset_i is the hard / power-up reset; bus_reset_i only clears index
`timescale 1ns/1ps
module cidr_config_regs
(
  // clock and hard reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  // ordinary bus reset pin
  input  wire logic                    bus_reset_i,
  // configuration mode from the key sequence
  input  wire logic                    cfg_mode_i,
  // host port strobes
  input  wire cidr_pkg::cidr_host_req_t host_req_i,
  // read answer
  output logic [7:0]                   rd_data_o,
  output logic                         rd_valid_o,
  // controls to the function units
  output cidr_pkg::cidr_ctrl_t         ctrl_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // keep writable bits from the host, force the fixed ones
  function automatic logic [7:0] merge_write(input logic [7:0] wdata,
                                             input logic [7:0] wmask,
                                             input logic [7:0] fixed);
    merge_write = (wdata & wmask) | (fixed & ~wmask);
  endfunction : merge_write

  // read value of a stored byte with its fixed bits applied
  function automatic logic [7:0] read_view(input logic [7:0] stored,
                                           input logic [7:0] wmask,
                                           input logic [7:0] fixed);
    read_view = (stored & wmask) | (fixed & ~wmask);
  endfunction : read_view

  ////////////////////////////////////////////////////////////////////////////
  // state

  cidr_pkg::cidr_state_t st_q;
  cidr_pkg::cidr_state_t st_d;

  logic       bus_reset_lvl;
  logic       ide_en;
  logic       alt_en;
  logic       pull_en;
  logic       lock_open;
  logic       in_lock_range;
  logic       access_ok;
  logic [1:0] pin_field_nx;
  logic [7:0] rd_mux;

  cidr_sync3 u_bus_reset_sync
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (bus_reset_i),
    .level_o   (bus_reset_lvl)
  );

  cidr_pin_decode u_pin_decode
  (
    .mode_field_i    (pin_field_nx),
    .ide_enable_o    (ide_en),
    .alt_ir_enable_o (alt_en),
    .pullup_enable_o (pull_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access qualification

  assign lock_open     = st_q.parallel_mode_and_lock[cidr_pkg::LOCK_BIT];
  assign in_lock_range = (st_q.index <= cidr_pkg::IDX_LOCK_TOP);
  // the lock covers the wider printed range, which includes every index here
  assign access_ok     = cfg_mode_i && (lock_open || !in_lock_range);

  // next pin field worked out from st_q, so the decoder does not feed back into st_d
  assign pin_field_nx  =
    (access_ok && host_req_i.data_wr && (st_q.index == cidr_pkg::IDX_PIN_FUNC))
      ? host_req_i.wdata[cidr_pkg::PIN_MODE_HI:cidr_pkg::PIN_MODE_LO]
      : st_q.pin_function_fdc_power[cidr_pkg::PIN_MODE_HI:cidr_pkg::PIN_MODE_LO];

  always_comb
  begin
    case (st_q.index)
      cidr_pkg::IDX_PIN_FUNC:
        rd_mux = read_view(st_q.pin_function_fdc_power,
                           cidr_pkg::WMASK_PIN_FUNC, cidr_pkg::FIXED_PIN_FUNC);
      cidr_pkg::IDX_PAR_LOCK:
        rd_mux = read_view(st_q.parallel_mode_and_lock,
                           cidr_pkg::WMASK_PAR_LOCK, cidr_pkg::FIXED_PAR_LOCK);
      cidr_pkg::IDX_SER_PWR:
        rd_mux = read_view(st_q.serial_power_control,
                           cidr_pkg::WMASK_SER_PWR, cidr_pkg::FIXED_SER_PWR);
      default:
        rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;

    // index port, only inside configuration mode
    if (cfg_mode_i && host_req_i.idx_wr)
    begin
      st_d.index = host_req_i.wdata;
    end
    // bus reset forgets the selection but keeps every register
    if (bus_reset_lvl)
    begin
      st_d.index = cidr_pkg::RST_INDEX;
    end

    // data port write uses the index held before this cycle
    if (access_ok && host_req_i.data_wr)
    begin
      case (st_q.index)
        cidr_pkg::IDX_PIN_FUNC:
          st_d.pin_function_fdc_power = merge_write(host_req_i.wdata,
            cidr_pkg::WMASK_PIN_FUNC, cidr_pkg::FIXED_PIN_FUNC);
        cidr_pkg::IDX_PAR_LOCK:
        begin
          st_d.parallel_mode_and_lock = merge_write(host_req_i.wdata,
            cidr_pkg::WMASK_PAR_LOCK, cidr_pkg::FIXED_PAR_LOCK);
          // lock can only fall; only a hard reset raises it again
          st_d.parallel_mode_and_lock[cidr_pkg::LOCK_BIT] =
            lock_open & host_req_i.wdata[cidr_pkg::LOCK_BIT];
        end
        cidr_pkg::IDX_SER_PWR:
          st_d.serial_power_control = merge_write(host_req_i.wdata,
            cidr_pkg::WMASK_SER_PWR, cidr_pkg::FIXED_SER_PWR);
        default:
          st_d.index = st_d.index;
      endcase
    end

    // data port read; a locked bank answers zero
    if (cfg_mode_i && host_req_i.data_rd)
    begin
      st_d.rd_valid = 1'b1;
      st_d.rd_data  = access_ok ? rd_mux : 8'h00;
    end

    // controls follow the new register values at the same edge
    st_d.ctrl.ide_enable      = ide_en;
    st_d.ctrl.alt_ir_enable   = alt_en;
    st_d.ctrl.pullup_enable   = pull_en;
    st_d.ctrl.fdc_power       =
      st_d.pin_function_fdc_power[cidr_pkg::FDC_PWR_BIT];
    // software flag only; nothing else in the bank looks at it
    st_d.ctrl.valid_flag      =
      st_d.pin_function_fdc_power[cidr_pkg::VALID_BIT];
    st_d.ctrl.pp_power        =
      st_d.parallel_mode_and_lock[cidr_pkg::PP_PWR_BIT];
    // extended mode choice itself lives in the extended setup register
    st_d.ctrl.pp_extended     =
      ~st_d.parallel_mode_and_lock[cidr_pkg::PP_MODE_BIT];
    st_d.ctrl.write_lock_open =
      st_d.parallel_mode_and_lock[cidr_pkg::LOCK_BIT];
    // power-down gates the unit only; its base decode stays live
    st_d.ctrl.primary_serial_port_power     =
      st_d.serial_power_control[cidr_pkg::PRIMARY_SERIAL_PORT_PWR_BIT];
    st_d.ctrl.secondary_serial_port_power     =
      st_d.serial_power_control[cidr_pkg::SECONDARY_SERIAL_PORT_PWR_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers: only the hard reset loads defaults

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q.index                  <= cidr_pkg::RST_INDEX;
      st_q.pin_function_fdc_power <= cidr_pkg::RST_PIN_FUNC;
      st_q.parallel_mode_and_lock <= cidr_pkg::RST_PAR_LOCK;
      st_q.serial_power_control   <= cidr_pkg::RST_SER_PWR;
      st_q.rd_data                <= 8'h00;
      st_q.rd_valid               <= 1'b0;
      st_q.ctrl.ide_enable        <= 1'b0;
      st_q.ctrl.alt_ir_enable     <= 1'b0;
      st_q.ctrl.pullup_enable     <= 1'b1;
      st_q.ctrl.fdc_power         <= 1'b1;
      st_q.ctrl.valid_flag        <= 1'b0;
      st_q.ctrl.pp_power          <= 1'b1;
      st_q.ctrl.pp_extended       <= 1'b0;
      st_q.ctrl.write_lock_open   <= 1'b1;
      st_q.ctrl.primary_serial_port_power       <= 1'b1;
      st_q.ctrl.secondary_serial_port_power       <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rd_data_o  = st_q.rd_data;
  assign rd_valid_o = st_q.rd_valid;
  assign ctrl_o     = st_q.ctrl;

endmodule : cidr_config_regs

// ==== cidr_host_model.sv ====
// Purpose: host processor model driving index and data port strobes
// Assumes: strobes are one-cycle pulses launched on the falling edge
// Notes:   released data lines carry the inverse byte, never the last one
`timescale 1ns/1ps
module cidr_host_model
(
  // clock
  input  wire logic                     ref_clk_i,
  // read answer
  input  wire logic [7:0]               rd_data_i,
  input  wire logic                     rd_valid_i,
  // strobes
  output cidr_pkg::cidr_host_req_t      host_req_o
);
  initial host_req_o = '0;

  //////////////////////////////////////////////////////////////////////////
  // k: 0 index write, 1 data write, 2 data read
  task automatic xfer(input int k, input logic [7:0] d,
                      output logic [7:0] q, output logic got);
    @(negedge ref_clk_i);
    host_req_o = '{idx_wr: k == 0, data_wr: k == 1, data_rd: k == 2, wdata: d};
    @(negedge ref_clk_i);
    host_req_o = '{idx_wr: 1'b0, data_wr: 1'b0, data_rd: 1'b0, wdata: ~d};
    // answer stands for one cycle only, so it is taken here or never
    got = (k == 2) && (rd_valid_i === 1'b1);
    q = rd_data_i;
  endtask : xfer
endmodule : cidr_host_model

// ==== cidr_config_regs_props.sv ====
// Purpose: port assertions for the configuration register bank
// Assumes: single clock, hard reset active high
// Notes:   the index is internal, so checks avoid per-index data
`timescale 1ns/1ps
module cidr_config_regs_props
(
  // clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     reset_i,
  // host side
  input wire logic                     bus_reset_i,
  input wire logic                     cfg_mode_i,
  input wire cidr_pkg::cidr_host_req_t host_req_i,
  // answers
  input wire logic [7:0]               rd_data_o,
  input wire logic                     rd_valid_o,
  input wire cidr_pkg::cidr_ctrl_t     ctrl_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire logic rd_take = host_req_i.data_rd && cfg_mode_i;
  wire logic wr_take = host_req_i.data_wr && cfg_mode_i;

  a_read_answer: assert property (rd_take |=> rd_valid_o && $stable(ctrl_o))
    else $error("read not answered");
  a_read_gated: assert property (!rd_take |=> !rd_valid_o)
    else $error("read answer without taken read");
  a_rd_data_hold: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved without answer");
  a_mode_excl: assert property (!(ctrl_o.ide_enable && ctrl_o.alt_ir_enable))
    else $error("ide and alternate both on");
  a_pullup_decode: assert property (ctrl_o.pullup_enable ==
    !(ctrl_o.ide_enable || ctrl_o.alt_ir_enable)) else $error("pullup decode wrong");
  a_lock_sticky: assert property (!ctrl_o.write_lock_open |=> !ctrl_o.write_lock_open)
    else $error("lock reopened");
  a_locked_read: assert property (rd_valid_o && !$past(ctrl_o.write_lock_open)
    |-> rd_data_o == 8'h00) else $error("locked read returned data");
  a_ctrl_quiet: assert property (!wr_take |=> $stable(ctrl_o))
    else $error("controls moved without write");
endmodule : cidr_config_regs_props

bind cidr_config_regs cidr_config_regs_props cidr_config_regs_props_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_reset_i(bus_reset_i),
  .cfg_mode_i(cfg_mode_i), .host_req_i(host_req_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .ctrl_o(ctrl_o));

// ==== cidr_config_regs_bench.sv ====
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model strobes at the falling edge, seed fixed at 54
// Notes:   shadow registers hold the readback form of each register
`timescale 1ns/1ps
module cidr_config_regs_bench;
  logic                     ref_clk_i;
  logic                     reset_i;
  logic                     bus_reset_i;
  logic                     cfg_mode_i;
  cidr_pkg::cidr_host_req_t host_req;
  logic [7:0]               rd_data;
  logic                     rd_valid;
  cidr_pkg::cidr_ctrl_t     ctrl;
  int                       miscompares = 0;
  int                       n_compared = 0;
  integer                   seed = 54;
  logic [7:0]               r0, r1, r2, q, v;
  logic                     got;

  cidr_config_regs cidr_config_regs_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus_reset_i(bus_reset_i), .cfg_mode_i(cfg_mode_i), .host_req_i(host_req),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ctrl_o(ctrl));
  cidr_host_model cidr_host_model_i (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .host_req_o(host_req));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rd_exp(input logic [7:0] i);
    // a closed lock blocks every register of this bank
    if (!r1[7]) return 8'h00;
    return (i == 8'h00) ? r0 : (i == 8'h01) ? r1 : (i == 8'h02) ? r2 : 8'h00;
  endfunction : rd_exp

  function automatic cidr_pkg::cidr_ctrl_t ctrl_exp();
    return '{ide_enable: r0[1:0] == 2'b10, alt_ir_enable: r0[1:0] == 2'b11,
      pullup_enable: !r0[1], fdc_power: r0[3], valid_flag: r0[7],
      pp_power: r1[2], pp_extended: !r1[3], write_lock_open: r1[7],
      primary_serial_port_power: r2[3], secondary_serial_port_power: r2[7]};
  endfunction : ctrl_exp

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    cidr_host_model_i.xfer(0, i, q, got);
    cidr_host_model_i.xfer(1, d, q, got);
    if (cfg_mode_i && r1[7])
      case (i)
        8'h00: r0 = (d & 8'h8b) | 8'h20;
        8'h01: r1 = (d & 8'h8c) | 8'h10;
        8'h02: r2 = d & 8'h88;
        default: ;
      endcase
  endtask : wr

  task automatic rd_chk(input logic [7:0] i);
    cidr_host_model_i.xfer(0, i, q, got);
    cidr_host_model_i.xfer(2, 8'h00, q, got);
    chk({7'h00, got, q}, {8'h01, rd_exp(i)});
  endtask : rd_chk

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    summarize();
  end

  initial
  begin
    {reset_i, bus_reset_i, cfg_mode_i} = 3'b101;
    {r0, r1, r2} = {8'h28, 8'h9c, 8'h88};
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i) reset_i = 1'b0;
    chk(ctrl, ctrl_exp());
    for (int i = 0; i < 4; i++) rd_chk(8'(i));
    for (int n = 0; n < 24; n++)
    begin
      v = $random(seed);
      v[1:0] = 2'(n / 3);
      if (n % 3 == 1) v[7] = 1'b1;
      wr(8'(n % 3), v);
      rd_chk(8'(n % 3));
      chk(ctrl, ctrl_exp());
    end
    // accesses outside configuration mode must leave no trace
    cfg_mode_i = 1'b0;
    wr(8'h00, ~r0);
    cidr_host_model_i.xfer(2, 8'h00, q, got);
    chk(got, 1'b0);
    cfg_mode_i = 1'b1;
    rd_chk(8'h00);
    cidr_host_model_i.xfer(0, 8'h02, q, got);
    bus_reset_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    bus_reset_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    cidr_host_model_i.xfer(2, 8'h00, q, got);
    chk(q, rd_exp(8'h00));
    chk(ctrl, ctrl_exp());
    wr(8'h01, 8'h00);
    chk(ctrl, ctrl_exp());
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h80);
    for (int i = 0; i < 3; i++) rd_chk(8'(i));
    chk(ctrl, ctrl_exp());
    reset_i = 1'b1;
    @(negedge ref_clk_i) reset_i = 1'b0;
    {r0, r1, r2} = {8'h28, 8'h9c, 8'h88};
    rd_chk(8'h01);
    chk(ctrl, ctrl_exp());
    summarize();
  end
endmodule : cidr_config_regs_bench
